/* File: design/rtc_read_pkg.sv */
// Purpose: Shared constants and types for the serial read engine
// Assumes: Byte-wide storage behind a 16-bit word address
// Notes:   Slave identifiers are the seven bits ahead of the direction bit
package rtc_read_pkg;

  // Slave identifiers, direction bit excluded
  localparam logic [6:0]  ID_ARRAY   = 7'h57;
  localparam logic [6:0]  ID_CTRL    = 7'h6F;

  // Counter and bit-count values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] ADDR_LAST  = 16'hFFFF;
  localparam logic [15:0] ADDR_STEP  = 16'h0001;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  BIT_STEP   = 4'h1;

  // Bus engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_DACK,
    ST_WADR,
    ST_WACK,
    ST_TX,
    ST_RACK,
    ST_WSTOP
  } bus_state_e;

  // Read request towards the storage
  typedef struct packed {
    logic        ctlSpace;
    logic [15:0] addr;
  } rd_req_s;

endpackage

/* File: design/rtc_serial_read_engine.sv */
// Purpose: Read side of the two-wire slave port (array and clock_control_space)
// Assumes: scl and sdaIn synchronous to clk_sys, many clocks per bus bit
// Notes:   rdData must be valid for memReq one clock after memReq changes
`timescale 1ns/1ps
module rtc_serial_read_engine (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  // Serial bus, open-drain data
  input  wire logic                    scl,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  // Storage read port
  output rtc_read_pkg::rd_req_s        memReq,
  input  wire logic [7:0]              rdData
);

  rtc_read_pkg::bus_state_e st_r;
  logic        sclPrev_r;
  logic        sdaPrev_r;
  logic [3:0]  bitCnt_r;
  logic [7:0]  shift_r;
  logic [15:0] addrCnt_r;
  logic [15:0] pendAddr_r;
  logic        havePend_r;
  logic        spaceCtl_r;
  logic        readDir_r;
  logic        wIdx_r;
  logic        ackd_r;
  logic        oe_r;

  // Bus event decode; start and stop only while scl holds high
  wire         startSeen = scl & sclPrev_r & sdaPrev_r & ~sdaIn;
  wire         stopSeen  = scl & sclPrev_r & ~sdaPrev_r & sdaIn;
  wire         sclRise   = scl & ~sclPrev_r;
  wire         sclFall   = ~scl & sclPrev_r;
  wire         byteFull  = (bitCnt_r == rtc_read_pkg::BYTE_BITS);
  wire [7:0]   shiftIn   = {shift_r[6:0], sdaIn};
  wire         isArray   = (shift_r[7:1] == rtc_read_pkg::ID_ARRAY);
  wire         isCtl     = (shift_r[7:1] == rtc_read_pkg::ID_CTRL);
  wire         isRead    = shift_r[0];
  // A read after a dummy write and repeated start must name the same space
  wire         spaceOk   = ~havePend_r | ~isRead | (isCtl == spaceCtl_r);
  wire         idOk      = (isArray | isCtl) & spaceOk;
  wire         devDecide = sclFall & (st_r == rtc_read_pkg::ST_DEV) & byteFull;
  // Loading a data byte happens after the read ack or after a master ack
  wire         txLoad    = sclFall & (((st_r == rtc_read_pkg::ST_DACK) & readDir_r)
                           | ((st_r == rtc_read_pkg::ST_RACK) & ~ackd_r));
  wire [15:0]  addrInc   = addrCnt_r + rtc_read_pkg::ADDR_STEP;

  // Outputs straight from flops; line is only ever pulled low
  assign sdaOe  = oe_r;
  assign memReq = '{ctlSpace: spaceCtl_r, addr: addrCnt_r};

  // Edge history of the bus pins
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      sdaOut    <= 1'b0;
    end else begin
      sclPrev_r <= scl;
      sdaPrev_r <= sdaIn;
      sdaOut    <= 1'b0;
    end
  end

  // Main bus engine; start and stop override every state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_r       <= rtc_read_pkg::ST_IDLE;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      addrCnt_r  <= rtc_read_pkg::ADDR_RESET;
      pendAddr_r <= rtc_read_pkg::ADDR_RESET;
      havePend_r <= 1'b0;
      spaceCtl_r <= 1'b0;
      wIdx_r     <= 1'b0;
      ackd_r     <= 1'b1;
      oe_r       <= 1'b0;
      readDir_r  <= 1'b0;
    end else if (startSeen) begin
      st_r     <= rtc_read_pkg::ST_DEV;
      bitCnt_r <= 4'h0;
      oe_r     <= 1'b0;
      if (havePend_r) begin
        addrCnt_r <= pendAddr_r;
      end
    end else if (stopSeen) begin
      st_r       <= rtc_read_pkg::ST_IDLE;
      oe_r       <= 1'b0;
      havePend_r <= 1'b0;
      if (havePend_r) begin
        addrCnt_r <= pendAddr_r;
      end
    end else begin
      unique case (st_r)
        rtc_read_pkg::ST_IDLE, rtc_read_pkg::ST_WSTOP: begin
          oe_r <= 1'b0;
        end
        rtc_read_pkg::ST_DEV, rtc_read_pkg::ST_WADR: begin
          if (sclRise && !byteFull) begin
            shift_r  <= shiftIn;
            bitCnt_r <= bitCnt_r + rtc_read_pkg::BIT_STEP;
          end else if (devDecide) begin
            // Pending address was taken at the repeated start; keeping it would
            // let the closing stop undo the counter advance of the read
            havePend_r <= 1'b0;
            readDir_r  <= isRead;
            if (idOk) begin
              st_r       <= rtc_read_pkg::ST_DACK;
              oe_r       <= 1'b1;
              spaceCtl_r <= isCtl;
            end else begin
              st_r <= rtc_read_pkg::ST_IDLE;
            end
          end else if (sclFall && byteFull) begin
            st_r <= rtc_read_pkg::ST_WACK;
            oe_r <= 1'b1;
            if (wIdx_r) begin
              pendAddr_r[7:0]  <= shift_r;
            end else begin
              pendAddr_r[15:8] <= shift_r;
            end
          end
        end
        rtc_read_pkg::ST_DACK: begin
          if (sclFall && !readDir_r) begin
            st_r     <= rtc_read_pkg::ST_WADR;
            oe_r     <= 1'b0;
            bitCnt_r <= 4'h0;
            wIdx_r   <= 1'b0;
          end
        end
        rtc_read_pkg::ST_WACK: begin
          if (sclFall) begin
            oe_r     <= 1'b0;
            bitCnt_r <= 4'h0;
            wIdx_r   <= 1'b1;
            // Second byte completes the word address; later bytes get no ack until start or stop
            if (wIdx_r) begin
              st_r       <= rtc_read_pkg::ST_WSTOP;
              havePend_r <= 1'b1;
            end else begin
              st_r <= rtc_read_pkg::ST_WADR;
            end
          end
        end
        rtc_read_pkg::ST_TX: begin
          if (sclFall) begin
            if (byteFull) begin
              st_r   <= rtc_read_pkg::ST_RACK;
              oe_r   <= 1'b0;
              ackd_r <= 1'b1;
            end else begin
              shift_r  <= {shift_r[6:0], 1'b0};
              oe_r     <= ~shift_r[6];
              bitCnt_r <= bitCnt_r + rtc_read_pkg::BIT_STEP;
            end
          end
        end
        rtc_read_pkg::ST_RACK: begin
          if (sclRise) begin
            ackd_r <= sdaIn;
          end else if (sclFall && ackd_r) begin
            st_r <= rtc_read_pkg::ST_WSTOP;
          end
        end
      endcase
      // First data bit is driven on the same fall that ends the ack slot
      if (txLoad) begin
        st_r      <= rtc_read_pkg::ST_TX;
        shift_r   <= rdData;
        oe_r      <= ~rdData[7];
        bitCnt_r  <= rtc_read_pkg::BIT_STEP;
        addrCnt_r <= addrInc;
      end
    end
  end

  // Checks on the engine
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence readAddrAcked;
    devDecide && idOk && isRead;
  endsequence

  sequence firstBitDriven;
    (st_r == rtc_read_pkg::ST_TX) && (bitCnt_r == rtc_read_pkg::BIT_STEP);
  endsequence

  a_reset_addr_zero: assert property (disable iff (1'b0)
    !rst_b |=> memReq.addr == 16'h0000)
    else $error("Counter not cleared by reset");

  a_read_ack_pull: assert property (readAddrAcked |=>
    sdaOe && (st_r == rtc_read_pkg::ST_DACK))
    else $error("Read slave byte not acknowledged");

  a_foreign_id_release: assert property (devDecide && !(isArray || isCtl) |=>
    !sdaOe [*2])
    else $error("Foreign slave byte acknowledged");

  a_space_mismatch: assert property (devDecide && havePend_r && isRead && (isCtl != spaceCtl_r) |=>
    (st_r == rtc_read_pkg::ST_IDLE) && !sdaOe)
    else $error("Read accepted for another space");

  a_setaddr_stop: assert property (stopSeen && havePend_r |=>
    (memReq.addr == $past(pendAddr_r)) && (st_r == rtc_read_pkg::ST_IDLE))
    else $error("Stop did not load word address");

  a_load_current_addr: assert property (txLoad |=>
    (shift_r == $past(rdData)) ##0 firstBitDriven)
    else $error("Data not taken from current address");

  a_step_and_wrap: assert property (txLoad |=>
    memReq.addr == $past(addrInc))
    else $error("Counter did not advance by one");

  a_wrap_to_first: assert property (txLoad && (addrCnt_r == rtc_read_pkg::ADDR_LAST) |=>
    memReq.addr == 16'h0000)
    else $error("Counter did not wrap to first location");

  a_ack_continues: assert property ((st_r == rtc_read_pkg::ST_RACK) && sclFall && !ackd_r
    && !startSeen && !stopSeen |=> st_r == rtc_read_pkg::ST_TX)
    else $error("Acknowledged byte not followed by data");

  a_nack_stops: assert property ((st_r == rtc_read_pkg::ST_RACK) && sclFall && ackd_r
    && !startSeen && !stopSeen |=> (st_r == rtc_read_pkg::ST_WSTOP) && !sdaOe)
    else $error("Transmission continued after no acknowledge");

  a_two_addr_bytes: assert property ((st_r == rtc_read_pkg::ST_WACK) && sclFall && wIdx_r
    && !startSeen && !stopSeen |=> havePend_r)
    else $error("Word address not complete after two bytes");

endmodule // rtc_serial_read_engine

/* File: bench/bus_master.sv */
// Purpose: Behavioural bus master for the serial read port
// Assumes: One bus bit spans 2*Q clk_sys cycles, pins change at falling clk
// Notes:   Releasing the data line means driving 1 into the wired-and
`timescale 1ns/1ps
module bus_master #(
  parameter int Q = 4
) (
  // Clock and resolved data line
  input  wire logic       clk_sys,
  input  wire logic       sdaWire,
  // Bus drive
  output logic            scl,
  output logic            sdaDrv,
  // Byte results, count bumps once per byte
  output logic [8:0]      resVal,
  output int              resCnt
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    resVal = 9'h000;
  end
  task automatic hold();
    repeat (Q) @(negedge clk_sys);
  endtask
  // One clock pulse, data sampled while scl is high
  task automatic pulse(output logic s);
    hold();
    scl = 1'b1;
    s = sdaWire;
    hold();
    scl = 1'b0;
  endtask
  // Start or repeated start, scl may be low on entry
  task automatic start();
    sdaDrv = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sdaDrv = 1'b0;
    hold();
    scl = 1'b0;
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sdaDrv = 1'b1;
    hold();
  endtask
  // Send a byte MSB first, result low bit is the device acknowledge
  task automatic wrByte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sdaDrv = b[i];
      pulse(s);
    end
    sdaDrv = 1'b1;
    pulse(s);
    resVal = {8'h00, ~s};
    resCnt++;
  endtask
  // Read a byte, then acknowledge or leave the slot released
  task automatic rdByte(input logic ack);
    logic [7:0] d;
    logic s;
    sdaDrv = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      d[i] = s;
    end
    sdaDrv = ~ack;
    pulse(s);
    // Next byte or start releases the line; no second drive in this step
    resVal = {d, 1'b1};
    resCnt++;
  endtask
endmodule // bus_master

/* File: bench/rtc_serial_read_engine_tb.sv */
// Purpose: Self-checking bench for the serial read engine
// Assumes: Storage is a combinational pattern of space and address
// Notes:   Expected bytes queue up before each transfer
`timescale 1ns/1ps
module rtc_serial_read_engine_tb;
  logic                  clk_sys, rst_b, scl, sdaDrv, sdaOut, sdaOe, sdaWire, sp;
  logic [8:0]            resVal;
  logic [7:0]            rdData;
  logic [15:0]           ptr;
  int                    resCnt, err_count, checked, cyc;
  logic [8:0]            notes[$];
  rtc_read_pkg::rd_req_s memReq;

  // Open drain with pull-up, device only ever pulls low
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  assign rdData = memFn(memReq.ctlSpace, memReq.addr);

  rtc_serial_read_engine rtc_serial_read_engine_inst (.clk_sys(clk_sys), .rst_b(rst_b), .scl(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .memReq(memReq), .rdData(rdData));
  bus_master bus_master_inst (.clk_sys(clk_sys), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv),
    .resVal(resVal), .resCnt(resCnt));

  // Sum keeps neighbours distinct across the wrap
  function automatic logic [7:0] memFn(input logic c, input logic [15:0] a);
    return 8'(a[7:0] + {a[12:8], a[15:13]} + (c ? 8'h5a : 8'h00));
  endfunction
  task automatic wb(input logic [7:0] b, input logic ack);
    notes.push_back({8'h00, ack});
    bus_master_inst.wrByte(b);
  endtask
  task automatic rb(input logic ack);
    notes.push_back({memFn(sp, ptr), 1'b1});
    ptr = ptr + 16'h0001;
    bus_master_inst.rdByte(ack);
  endtask
  // Dummy write of two address bytes, optionally closed by stop
  task automatic setAdr(input logic c, input logic [15:0] a, input logic viaStop);
    bus_master_inst.start();
    wb(c ? 8'hde : 8'hae, 1'b1);
    wb(a[15:8], 1'b1);
    wb(a[7:0], 1'b1);
    if (viaStop) bus_master_inst.stop();
    ptr = a;
  endtask
  task automatic curRd(input logic c, input int n);
    bus_master_inst.start();
    wb(c ? 8'hdf : 8'haf, 1'b1);
    sp = c;
    for (int i = 0; i < n; i++) rb(i != n - 1);
    bus_master_inst.stop();
  endtask
  task automatic print_verdict();
    if (notes.size() != 0) err_count++;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Oldest note against each byte result
  // Short wait lets the byte value settle through the port before it is read
  always @(resCnt) begin
    #1;
    checked++;
    if (notes.size() == 0 || resVal !== notes[0]) begin
      err_count++;
      $display("BAD bus byte exp %h seen %h", notes.size() ? notes[0] : 9'h000, resVal);
    end
    if (notes.size()) void'(notes.pop_front());
  end
  // Hang guard, about four times the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
      err_count++;
      $display("BAD run length exp 12000 seen more");
      print_verdict();
    end
  end
  initial begin
    void'($urandom(93377));
    rst_b = 1'b0;
    sp = 1'b0;
    ptr = 16'h0000;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    curRd(1'b0, 3);
    setAdr(1'b1, 16'hfffe, 1'b1);
    curRd(1'b1, 4);
    for (int k = 0; k < 3; k++) begin
      setAdr(k[0], 16'($urandom), 1'b0);
      curRd(k[0], 2);
    end
    // Extra byte after no-ack must read as released
    bus_master_inst.start();
    wb(8'haf, 1'b1);
    rb(1'b0);
    notes.push_back({8'hff, 1'b1});
    bus_master_inst.rdByte(1'b0);
    bus_master_inst.stop();
    bus_master_inst.start();
    wb(8'ha1, 1'b0);
    bus_master_inst.stop();
    // Space differs between dummy write and read phase
    setAdr(1'b0, 16'h0010, 1'b0);
    bus_master_inst.start();
    wb(8'hdf, 1'b0);
    bus_master_inst.stop();
    print_verdict();
  end
endmodule // rtc_serial_read_engine_tb
